// *** hw/bpc_consts.vh ***
/*
 Constants of the brushless pre-driver control block: clock rate, timer
 lengths, register offsets and field positions.
 Assumes inclusion by bare name from the hw/ design files.
*/
`ifndef BPC_CONSTS_VH
`define BPC_CONSTS_VH

`define BPC_CLK_MHZ      25
`define BPC_TOFF_NS      25000
`define BPC_TOFF_CYC     ((`BPC_TOFF_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_BLANK_NS     1500
`define BPC_BLANK_CYC    ((`BPC_BLANK_NS * `BPC_CLK_MHZ + 999) / 1000)
`define BPC_STBY_US      3000
`define BPC_STBY_CYC     (`BPC_STBY_US * `BPC_CLK_MHZ)
`define BPC_TMR_W        17
`define BPC_LOCK_TICKS   7'h7F
`define BPC_LOCK_HALF    7'h40
`define BPC_LOCK_W       7

`define BPC_ADDR_W       4
`define BPC_ADDR_CTRL    4'h0
`define BPC_ADDR_STAT    4'h4
`define BPC_ADDR_LOCK    4'h8
`define BPC_CTRL_W       2
`define BPC_CTRL_RST     2'h3
`define BPC_CTRL_LOCKEN  0
`define BPC_CTRL_SREN    1

`define BPC_SYNC_W       13
`define BPC_SYNC_RST     13'h0400
`define BPC_HALL_BAD     3'h7
`define BPC_HALL_LAST    3'h5

`endif

// *** hw/bpc_sync.v ***
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the bits are independent levels; reset value is a parameter so
 that a fault level can be held asserted until the pin has been seen.
*/
`default_nettype none
module bpc_sync #(
   parameter W    = 1,
   parameter RSTV = 0
) (
   input  wire         mclk,
   input  wire         reset_n,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] meta_r;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= RSTV[W-1:0];
         dout   <= RSTV[W-1:0];
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule
`default_nettype wire

// *** hw/bpc_timer.v ***
/*
 Reloadable down counter; busy while the count is non-zero.
 Assumes load is a one-cycle request on the same clock.
*/
`default_nettype none
module bpc_timer #(
   parameter W = 8
) (
   input  wire         mclk,
   input  wire         reset_n,
   input  wire         load,
   input  wire [W-1:0] loadVal,
   output wire         busy
);
   reg [W-1:0] cnt_r;

   assign busy = (cnt_r != {W{1'b0}});

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= {W{1'b0}};
      end else if (load) begin
         cnt_r <= loadVal;
      end else if (busy) begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

// *** hw/bpc_control.v ***
/*
 Control logic of a three-phase brushless pre-driver: commutation, fixed
 off-time chopping with blanking, external chop input, synchronous
 rectification, brake, standby, fault shutdown, tachometer outputs and
 locked-rotor detection, plus an APB register slave.
 Assumes pins are asynchronous to mclk; the current comparator, fault
 monitors and the lock oscillator square wave arrive as digital levels.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
`include "bpc_consts.vh"

module bpc_control #(
   parameter STBY_CYC = `BPC_STBY_CYC
) (
   input  wire        mclk,
   input  wire        reset_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [3:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        chopInput,
   input  wire        dirIn,
   input  wire        brakeRequest_n,
   input  wire        phaseAHallInput,
   input  wire        hallB,
   input  wire        hallC,
   input  wire        tripCurrent,
   input  wire        overTemp,
   input  wire        pumpRailUv,
   input  wire        motorSupplyUv,
   input  wire        supplyOvervoltage,
   input  wire        lockTimingCapGnd,
   input  wire        lockOsc,
   output reg         gateHiA,
   output reg         gateLoA,
   output reg         gateHiB,
   output reg         gateLoB,
   output reg         gateHiC,
   output reg         gateLoC,
   output reg         hallSupplyOutput,
   output reg         hallEdgeTachOut,
   output reg         hallEdgeTachOe,
   output reg         phaseATachOut,
   output reg         phaseATachOe
);
   // commutation: {high side A,B,C, low side A,B,C}; invalid hall codes give all off
   function [5:0] commute;
      input [2:0] h;
      input       fwd;
      reg   [5:0] f;
      begin
         case (h)
            3'b101:  f = 6'b100_010;
            3'b001:  f = 6'b100_001;
            3'b011:  f = 6'b010_001;
            3'b010:  f = 6'b010_100;
            3'b110:  f = 6'b001_100;
            3'b100:  f = 6'b001_010;
            default: f = 6'b000_000;
         endcase
         commute = fwd ? f : {f[2:0], f[5:3]};
      end
   endfunction

   // position of a hall code in the commutation cycle
   function [2:0] hallIdx;
      input [2:0] h;
      begin
         case (h)
            3'b101:  hallIdx = 3'h0;
            3'b100:  hallIdx = 3'h1;
            3'b110:  hallIdx = 3'h2;
            3'b010:  hallIdx = 3'h3;
            3'b011:  hallIdx = 3'h4;
            3'b001:  hallIdx = 3'h5;
            default: hallIdx = `BPC_HALL_BAD;
         endcase
      end
   endfunction

   function [2:0] idxNext;
      input [2:0] i;
      begin
         idxNext = (i == `BPC_HALL_LAST) ? 3'h0 : i + 3'h1;
      end
   endfunction

   wire [`BPC_SYNC_W-1:0] pinS;
   wire       chop, dir, brakeN, trip, ot, pumpUv, supUv, supOv, capGnd, osc;
   wire [2:0] hall;

   bpc_sync #(.W(`BPC_SYNC_W), .RSTV(`BPC_SYNC_RST)) uSync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .din     ({lockOsc, supplyOvervoltage, motorSupplyUv, pumpRailUv, overTemp,
                 lockTimingCapGnd, tripCurrent, hallC, hallB, phaseAHallInput,
                 brakeRequest_n, dirIn, chopInput}),
      .dout    (pinS)
   );
   assign chop   = pinS[0];
   assign dir    = pinS[1];
   assign brakeN = pinS[2];
   assign hall   = pinS[5:3];
   assign trip   = pinS[6];
   assign capGnd = pinS[7];
   assign ot     = pinS[8];
   assign pumpUv = pinS[9];
   assign supUv  = pinS[10];
   assign supOv  = pinS[11];
   assign osc    = pinS[12];

   reg  [`BPC_CTRL_W-1:0] ctrl_r;
   reg                    chopPrev_r, dirPrev_r, oscPrev_r, uvPrev_r;
   reg  [2:0]             hallPrev_r, hallOld_r;
   reg                    srcLatch_r, offWasBusy_r;
   reg  [`BPC_TMR_W-1:0]  chopCnt_r;
   reg                    standby_r;
   reg  [`BPC_LOCK_W-1:0] lockCnt_r, halfCnt_r;
   reg                    lockLatched_r;
   reg  [5:0]             gate_nxt;

   wire chopOn   = chopPrev_r & ~chop;
   wire dirEdge  = dir ^ dirPrev_r;
   wire oscTick  = osc & ~oscPrev_r;
   wire uvRecov  = uvPrev_r & ~supUv;
   wire hallEdge = (hall != hallPrev_r);
   wire braking  = ~brakeN;
   wire faultOff = ot | pumpUv | supUv;
   wire chopLong = chop & (chopCnt_r >= STBY_CYC[`BPC_TMR_W-1:0]);
   wire offBusy, blankBusy;

   wire [5:0] sel    = commute(hall, dir);
   wire       driving = ~chop & srcLatch_r & ~faultOff & brakeN;

   // a trip seen during blanking is the turn-on spike, not winding current
   wire tripEvt  = trip & driving & ~blankBusy & ~offBusy;
   wire offDone  = offWasBusy_r & ~offBusy;
   wire blankGo  = offDone | chopOn | dirEdge;

   // the latch sets one cycle after the count empties, so load one short
   localparam integer TOFF_LOAD  = `BPC_TOFF_CYC - 1;
   localparam integer BLANK_LOAD = `BPC_BLANK_CYC;

   bpc_timer #(.W(`BPC_TMR_W)) uOff (
      .mclk    (mclk),
      .reset_n (reset_n),
      .load    (tripEvt),
      .loadVal (TOFF_LOAD[`BPC_TMR_W-1:0]),
      .busy    (offBusy)
   );

   bpc_timer #(.W(`BPC_TMR_W)) uBlank (
      .mclk    (mclk),
      .reset_n (reset_n),
      .load    (blankGo),
      .loadVal (BLANK_LOAD[`BPC_TMR_W-1:0]),
      .busy    (blankBusy)
   );

   // hall order check: a step must go one place either way and not bounce back
   wire [2:0] iNew = hallIdx(hall);
   wire [2:0] iPrv = hallIdx(hallPrev_r);
   wire [2:0] iOld = hallIdx(hallOld_r);
   wire stepOk = hallEdge & (iNew != `BPC_HALL_BAD) & (iPrv != `BPC_HALL_BAD)
               & ((iNew == idxNext(iPrv)) | (iPrv == idxNext(iNew)))
               & (iNew != iOld);
   wire lockEn = ctrl_r[`BPC_CTRL_LOCKEN] & ~capGnd;
   wire lockClr = dirEdge | uvRecov | (chop & (halfCnt_r >= `BPC_LOCK_HALF));
   wire lockHit = lockEn & brakeN & ~chop & oscTick
                & (lockCnt_r == `BPC_LOCK_TICKS - 7'h01);

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         chopPrev_r   <= 1'b0;
         dirPrev_r    <= 1'b0;
         oscPrev_r    <= 1'b0;
         uvPrev_r     <= 1'b1;
         hallPrev_r   <= 3'h0;
         hallOld_r    <= 3'h0;
         offWasBusy_r <= 1'b0;
      end else begin
         chopPrev_r   <= chop;
         dirPrev_r    <= dir;
         oscPrev_r    <= osc;
         uvPrev_r     <= supUv;
         hallPrev_r   <= hall;
         offWasBusy_r <= offBusy;
         if (hallEdge) begin
            hallOld_r <= hallPrev_r;
         end
      end
   end

   // source enable latch: cleared by a trip, set again once off-time ends
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         srcLatch_r <= 1'b1;
      end else if (tripEvt) begin
         srcLatch_r <= 1'b0;
      end else if (offDone) begin
         srcLatch_r <= 1'b1;
      end
   end

   // chop-high duration, saturating so a long hold stays in standby
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         chopCnt_r <= {`BPC_TMR_W{1'b0}};
         standby_r <= 1'b0;
      end else begin
         if (!chop) begin
            chopCnt_r <= {`BPC_TMR_W{1'b0}};
         end else if (!chopLong) begin
            chopCnt_r <= chopCnt_r + {{(`BPC_TMR_W-1){1'b0}}, 1'b1};
         end
         standby_r <= chopLong & brakeN;
      end
   end

   // lock detect: counts oscillator cycles with no in-order hall step
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lockCnt_r     <= {`BPC_LOCK_W{1'b0}};
         halfCnt_r     <= {`BPC_LOCK_W{1'b0}};
         lockLatched_r <= 1'b0;
      end else begin
         if (!lockEn || braking || chop || stepOk || lockLatched_r) begin
            lockCnt_r <= {`BPC_LOCK_W{1'b0}};
         end else if (oscTick) begin
            lockCnt_r <= lockCnt_r + 7'h01;
         end
         if (!chop) begin
            halfCnt_r <= {`BPC_LOCK_W{1'b0}};
         end else if (oscTick && halfCnt_r != `BPC_LOCK_TICKS) begin
            halfCnt_r <= halfCnt_r + 7'h01;
         end
         if (lockHit) begin
            lockLatched_r <= 1'b1;
         end else if (lockClr || !lockEn) begin
            lockLatched_r <= 1'b0;
         end
      end
   end

   // gate selection, highest priority first
   always @* begin
      gate_nxt = 6'b000_000;
      if (faultOff) begin
         gate_nxt = 6'b000_000;
      end else if (braking) begin
         gate_nxt = 6'b000_111;
      end else if (chopLong || lockLatched_r) begin
         gate_nxt = 6'b000_000;
      end else if (driving) begin
         gate_nxt = sel;
      end else if (ctrl_r[`BPC_CTRL_SREN] && !supOv) begin
         // slow decay: source phase low side on, current circulates via low sides
         gate_nxt = {3'b000, sel[2:0] | sel[5:3]};
      end else begin
         gate_nxt = {3'b000, sel[2:0]};
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gateHiA          <= 1'b0;
         gateHiB          <= 1'b0;
         gateHiC          <= 1'b0;
         gateLoA          <= 1'b0;
         gateLoB          <= 1'b0;
         gateLoC          <= 1'b0;
         hallSupplyOutput <= 1'b1;
         hallEdgeTachOut  <= 1'b0;
         hallEdgeTachOe   <= 1'b0;
         phaseATachOut    <= 1'b0;
         phaseATachOe     <= 1'b0;
      end else begin
         gateHiA          <= gate_nxt[5];
         gateHiB          <= gate_nxt[4];
         gateHiC          <= gate_nxt[3];
         gateLoA          <= gate_nxt[2];
         gateLoB          <= gate_nxt[1];
         gateLoC          <= gate_nxt[0];
         hallSupplyOutput <= ~standby_r;
         if (hallEdge) begin
            hallEdgeTachOe <= ~hallEdgeTachOe;
         end
         if (hall[0] != hallPrev_r[0]) begin
            phaseATachOe <= ~phaseATachOe;
         end
      end
   end

   // APB slave: zero wait states, read data captured in the setup phase
   wire setup  = psel & ~penable;
   wire access = psel & penable;
   wire mapped = (paddr == `BPC_ADDR_CTRL) | (paddr == `BPC_ADDR_STAT)
               | (paddr == `BPC_ADDR_LOCK);
   wire roHit  = (paddr == `BPC_ADDR_STAT) | (paddr == `BPC_ADDR_LOCK);

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r  <= `BPC_CTRL_RST;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            pslverr <= ~mapped | (pwrite & roHit);
            case (paddr)
               `BPC_ADDR_CTRL: prdata <= {30'h0, ctrl_r};
               `BPC_ADDR_STAT: prdata <= {19'h0, hallEdgeTachOe, phaseATachOe, hall,
                                          standby_r, lockLatched_r, braking, srcLatch_r,
                                          supOv, supUv, pumpUv, ot};
               `BPC_ADDR_LOCK: prdata <= {17'h0, halfCnt_r, 1'b0, lockCnt_r};
               default:        prdata <= 32'h0000_0000;
            endcase
         end
         if (access && pwrite && paddr == `BPC_ADDR_CTRL) begin
            ctrl_r <= pwdata[`BPC_CTRL_W-1:0];
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/bpc_control_assertions.sv ***
/*
 Checker for the pre-driver control block: pin to gate, hall supply and tach relations.
 Assumes only the top module's ports; bound to every bpc_control.
*/
`default_nettype none
module bpc_control_assertions #(
   parameter STBY_CYC = 75000
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic chopInput,
   input wire logic brakeRequest_n,
   input wire logic phaseAHallInput,
   input wire logic hallB,
   input wire logic hallC,
   input wire logic overTemp,
   input wire logic pumpRailUv,
   input wire logic motorSupplyUv,
   input wire logic gateHiA,
   input wire logic gateLoA,
   input wire logic gateHiB,
   input wire logic gateLoB,
   input wire logic gateHiC,
   input wire logic gateLoC,
   input wire logic hallSupplyOutput,
   input wire logic hallEdgeTachOe,
   input wire logic phaseATachOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [16:0] chopRun_r;
   wire         hiAny  = gateHiA | gateHiB | gateHiC;
   wire         noGate = !hiAny && !(gateLoA | gateLoB | gateLoC);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // raw pin count; the block's own count lags it, so >= stays safe
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         chopRun_r <= 17'h00000;
      else if (!chopInput)
         chopRun_r <= 17'h00000;
      else if (chopRun_r != 17'h1FFFF)
         chopRun_r <= chopRun_r + 17'h00001;
   end

   property p_brake;
      (!brakeRequest_n && !overTemp && !pumpRailUv && !motorSupplyUv)[*5]
         |-> gateLoA && gateLoB && gateLoC && !hiAny;
   endproperty
   a_brake: assert property (p_brake) else $error("sinks not all on in brake");
   property p_ot;
      $rose(overTemp) ##1 overTemp[*4] |-> noGate;
   endproperty
   a_ot: assert property (p_ot) else $error("gates on while too hot");
   property p_pump;
      pumpRailUv[*5] |-> noGate;
   endproperty
   a_pump: assert property (p_pump) else $error("gates on with pump rail fault");
   property p_supUv;
      motorSupplyUv[*5] |-> noGate;
   endproperty
   a_supUv: assert property (p_supUv) else $error("gates on in supply undervoltage");
   property p_chop;
      chopInput[*5] |-> !hiAny;
   endproperty
   a_chop: assert property (p_chop) else $error("source on while chopped");
   property p_brakeStby;
      !brakeRequest_n[*5] |-> hallSupplyOutput;
   endproperty
   a_brakeStby: assert property (p_brakeStby) else $error("standby during brake");
   property p_stby;
      $fell(hallSupplyOutput) |-> chopRun_r >= STBY_CYC;
   endproperty
   a_stby: assert property (p_stby) else $error("hall supply off too early");
   property p_tachA;
      $changed(phaseAHallInput) |-> ##[2:6] $changed(phaseATachOe);
   endproperty
   a_tachA: assert property (p_tachA) else $error("phase tach missed an edge");
   property p_tachAny;
      $changed({hallC, hallB, phaseAHallInput}) |-> ##[2:6] $changed(hallEdgeTachOe);
   endproperty
   a_tachAny: assert property (p_tachAny) else $error("hall tach missed an edge");
endmodule

bind bpc_control bpc_control_assertions #(.STBY_CYC(STBY_CYC)) uChk (
   .mclk(mclk), .reset_n(reset_n), .chopInput(chopInput), .brakeRequest_n(brakeRequest_n),
   .phaseAHallInput(phaseAHallInput), .hallB(hallB), .hallC(hallC), .overTemp(overTemp),
   .pumpRailUv(pumpRailUv), .motorSupplyUv(motorSupplyUv), .gateHiA(gateHiA),
   .gateLoA(gateLoA), .gateHiB(gateHiB), .gateLoB(gateLoB), .gateHiC(gateHiC),
   .gateLoC(gateLoC), .hallSupplyOutput(hallSupplyOutput), .hallEdgeTachOe(hallEdgeTachOe),
   .phaseATachOe(phaseATachOe));
`default_nettype wire

// *** verification/bpc_motor_model.sv ***
/*
 Motor winding and lock oscillator model facing the gate outputs.
 Assumes gates ordered {hiA, loA, hiB, loB, hiC, loC}, high = on.
*/
`default_nettype none
module bpc_motor_model #(
   parameter int TRIP_TH = 10
) (
   input  wire logic       mclk,
   input  wire logic       loadOn,
   input  wire logic       oscOn,
   input  wire logic [5:0] gates,
   output wire logic       tripCurrent,
   output wire logic       lockOsc
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cur   = 0;
   logic ph    = 1'b0;
   logic osc_r = 1'b0;
   assign lockOsc = osc_r;
   // current climbs while any source is on, falls in decay
   always @(posedge mclk) begin
      if (!loadOn)
         cur <= 0;
      else if (gates[5] | gates[3] | gates[1])
         cur <= cur + 1;
      else if (cur > 0)
         cur <= cur - 1;
      ph <= oscOn & !ph;
      if (oscOn && ph)
         osc_r <= !osc_r;
   end
   assign tripCurrent = loadOn && cur >= TRIP_TH;
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
/*
 Self-checking bench for the pre-driver control block.
 Assumes the motor model answers the trip and lock oscillator pins.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STBY = 200;
   logic        mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [3:0]  paddr = 4'h0;
   logic [31:0] pwdata = 32'h0, rd;
   logic        chopInput = 0, dirIn = 1, brake_n = 1, ot = 0, pumpUv = 0, supUv = 0;
   logic        ov = 0, capGnd = 0, loadOn = 0, oscOn = 0, eE = 0, eA = 0;
   logic [2:0]  hall = 3'h0;
   wire  [31:0] prdata;
   wire  [5:0]  g;
   wire         pready, pslverr, trip, lockOsc, hSup, eOut, eOe, aOut, aOe;
   int          mismatches = 0, checkCount = 0, n;
   logic [3:0]  rin [14] = '{4'hD, 4'h9, 4'hB, 4'hA, 4'hE, 4'hC, 4'h5, 4'h4, 4'h6,
                             4'h2, 4'h3, 4'h1, 4'hF, 4'h0};
   logic [5:0]  rout [14] = '{6'h24, 6'h21, 6'h09, 6'h18, 6'h12, 6'h06, 6'h18, 6'h09,
                              6'h21, 6'h24, 6'h06, 6'h12, 6'h00, 6'h00};

   always #20 mclk = ~mclk;

   bpc_control #(.STBY_CYC(STBY)) DUT (
      .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chopInput(chopInput), .dirIn(dirIn), .brakeRequest_n(brake_n),
      .phaseAHallInput(hall[0]), .hallB(hall[1]), .hallC(hall[2]), .tripCurrent(trip),
      .overTemp(ot), .pumpRailUv(pumpUv), .motorSupplyUv(supUv), .supplyOvervoltage(ov),
      .lockTimingCapGnd(capGnd), .lockOsc(lockOsc), .gateHiA(g[5]), .gateLoA(g[4]),
      .gateHiB(g[3]), .gateLoB(g[2]), .gateHiC(g[1]), .gateLoC(g[0]),
      .hallSupplyOutput(hSup), .hallEdgeTachOut(eOut), .hallEdgeTachOe(eOe),
      .phaseATachOut(aOut), .phaseATachOe(aOe));
   bpc_motor_model #(.TRIP_TH(10)) uMotor (.mclk(mclk), .loadOn(loadOn), .oscOn(oscOn),
      .gates(g), .tripCurrent(trip), .lockOsc(lockOsc));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask
   // bounded wait for a gate pattern; n returns the cycles spent
   task automatic waitg(input logic [5:0] v, input int lim);
      n = 0;
      while (g !== v && n < lim) begin
         cyc(1);
         n++;
      end
      if (g !== v) begin
         check(g, v);
         conclude();
      end
   endtask
   task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int w;
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge mclk);
      penable <= 1;
      w = 0;
      do begin
         @(posedge mclk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) begin
         check(pready, 1);
         conclude();
      end
   endtask
   // the model makes one oscillator rise per four clocks
   task automatic ticks(input int t);
      @(posedge mclk);
      oscOn <= 1;
      repeat (4 * t) @(posedge mclk);
      oscOn <= 0;
      cyc(2);
   endtask

   initial begin
      cyc(3);
      check({22'h0, g, hSup, pready, eOe, aOe}, 32'h8);
      repeat (3) @(posedge mclk);
      reset_n <= 1;
      apb(0, 4'h0, 32'h0);
      check(rd, 32'h3);
      for (int i = 0; i < 14; i++) begin
         @(posedge mclk);
         {dirIn, hall} <= rin[i];
         eE ^= (rin[i][2:0] != hall);
         eA ^= (rin[i][0] != hall[0]);
         cyc(6);
         check(g, rout[i]);
         check({eOut, aOut, eOe, aOe}, {2'b00, eE, eA});
      end
      @(posedge mclk);
      {dirIn, hall, chopInput, brake_n} <= 6'h36;
      cyc(6);
      check(g, 6'h15);
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk);
         {ot, pumpUv, supUv} <= 3'h4 >> k;
         cyc(6);
         check(g, 6'h00);
      end
      @(posedge mclk);
      supUv <= 0;
      cyc(STBY + 20);
      check({g, hSup}, 7'h2B);
      @(posedge mclk);
      {chopInput, brake_n} <= 2'b01;
      cyc(6);
      check(g, 6'h24);
      @(posedge mclk);
      chopInput <= 1;
      cyc(6);
      check(g, 6'h14);
      apb(1, 4'h0, 32'h1);
      cyc(6);
      check({er, g}, 7'h04);
      apb(1, 4'h0, 32'h3);
      @(posedge mclk);
      ov <= 1;
      cyc(6);
      check(g, 6'h04);
      cyc(STBY - 40);
      check(hSup, 1);
      cyc(50);
      check(hSup, 0);
      check(g, 6'h00);
      @(posedge mclk);
      ov <= 0;
      apb(0, 4'hC, 32'h0);
      check({er, rd}, 33'h100000000);
      apb(1, 4'h4, 32'hFFFF);
      check(er, 1);
      @(posedge mclk);
      chopInput <= 0;
      cyc(6);
      @(posedge mclk);
      loadOn <= 1;
      waitg(6'h14, 200);
      waitg(6'h24, 700);
      check(n, 625);
      waitg(6'h14, 200);
      check(n >= 30 && n <= 50, 1);
      @(posedge mclk);
      loadOn <= 0;
      // let the last off-time run out before the lock cases
      cyc(640);
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         {brake_n, capGnd} <= k ? 2'b11 : 2'b00;
         ticks(130);
         @(posedge mclk);
         {brake_n, capGnd} <= 2'b10;
         cyc(6);
         check(g, 6'h24);
      end
      ticks(126);
      cyc(6);
      check(g, 6'h24);
      ticks(1);
      cyc(6);
      check(g, 6'h00);
      @(posedge mclk);
      dirIn <= 0;
      cyc(8);
      check(g, 6'h18);
      // bouncing between two hall states is not progress
      for (int k = 0; k < 130; k++) begin
         @(posedge mclk);
         hall[0] <= ~hall[0];
         ticks(1);
      end
      check(g, 6'h00);
      @(posedge mclk);
      chopInput <= 1;
      ticks(70);
      @(posedge mclk);
      chopInput <= 0;
      cyc(8);
      check(g, 6'h18);
      conclude();
   end
endmodule
`default_nettype wire
